//--- hdl/ssr_pkg.sv
// Package for the status summary reporting block: field positions, masks, command codes
package ssr_pkg;

   // ==========================================================
   // Status byte field positions
   localparam int unsigned SB_ERRQ_BIT = 2;
   localparam int unsigned SB_QUES_BIT = 3;
   localparam int unsigned SB_MAV_BIT  = 4;
   localparam int unsigned SB_STDE_BIT = 5;
   localparam int unsigned SB_MSS_BIT  = 6;
   localparam int unsigned SB_OPER_BIT = 7;

   // ==========================================================
   // Group bit positions and implemented-bit masks
   localparam int unsigned QC_PROT_BIT = 0;
   localparam int unsigned QC_FREF_BIT = 5;
   localparam int unsigned QC_USB_BIT  = 7;
   localparam int unsigned OC_RUN_BIT  = 8;
   localparam logic [15:0] QUES_MASK   = 16'h00a1;
   localparam logic [15:0] OPER_MASK   = 16'h0100;

   // ==========================================================
   // Reset and preset values
   localparam logic [15:0] ENABLE_PRESET = 16'h0000;
   localparam logic [15:0] PTR_PRESET    = 16'hffff;
   localparam logic [15:0] NTR_PRESET    = 16'h0000;
   localparam logic [7:0]  SRE_RESET     = 8'h00;

   // ==========================================================
   // Group select and register select codes
   typedef enum logic [0:0] {
      SSR_GRP_QUES = 1'h0,
      SSR_GRP_OPER = 1'h1
   } ssr_group_e;

   typedef enum logic [2:0] {
      SSR_REG_EVENT = 3'h0,
      SSR_REG_COND  = 3'h1,
      SSR_REG_ENAB  = 3'h2,
      SSR_REG_NTR   = 3'h3,
      SSR_REG_PTR   = 3'h4
   } ssr_reg_e;

   // Command from the command parser
   typedef struct packed {
      logic       read;    // Query strobe
      logic       write;   // Set strobe
      ssr_group_e group;
      ssr_reg_e   sel;
      logic [15:0] wdata;
   } ssr_cmd_s;

   // Answer to a query
   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } ssr_rsp_s;

endpackage : ssr_pkg

//--- hdl/ssr_status.sv
// Status summary reporting block: event groups, status byte and service request
// ==========================================================
`timescale 1ns/10ps
`default_nettype none

module ssr_status (
   // Clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_reset,
   // Live conditions from the instrument
   input  wire logic             i_prot_off,
   input  wire logic             i_fref_bad,
   input  wire logic             i_usb_lost,
   input  wire logic             i_running,
   // Summary sources outside this block
   input  wire logic             i_errq_nonempty,
   input  wire logic             i_outbuf_nonempty,
   input  wire logic             i_std_event_any,
   // Common commands
   input  wire logic             i_clear_status,
   input  wire logic             i_preset,
   input  wire logic             i_sre_write,
   input  wire logic [7:0]       i_sre_wdata,
   // Group register access
   input  wire ssr_pkg::ssr_cmd_s i_cmd,
   output var ssr_pkg::ssr_rsp_s o_rsp,
   // Status byte and service request
   output logic [7:0]            o_status_byte,
   output logic [7:0]            o_sre,
   output logic                  o_srq
);
   import ssr_pkg::*;

   // ==========================================================
   // Group state, index 0 questionable, 1 operation
   logic [15:0] cond_reg  [2];
   logic [15:0] prev_reg  [2];
   logic [15:0] event_reg [2];
   logic [15:0] enab_reg  [2];
   logic [15:0] ptr_reg   [2];
   logic [15:0] ntr_reg   [2];
   logic [15:0] grp_mask  [2];
   logic [15:0] live      [2];
   logic [1:0]  evt_clear;
   logic [1:0]  grp_sum;
   logic [7:0]  sb_next;
   logic [7:0]  sre_reg;
   logic [7:0]  sb_prev_reg;

   assign grp_mask[0] = QUES_MASK;
   assign grp_mask[1] = OPER_MASK;

   // Live condition map
   always_comb begin
      live[0] = 16'h0000;
      live[1] = 16'h0000;
      live[0][QC_PROT_BIT] = i_prot_off;
      live[0][QC_FREF_BIT] = i_fref_bad;
      live[0][QC_USB_BIT]  = i_usb_lost;
      live[1][OC_RUN_BIT]  = i_running;
   end

   // ==========================================================
   // Per-group register logic
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_grp
         logic hit;
         logic [15:0] rise;
         logic [15:0] fall;
         // Access addressed to this group
         assign hit  = (i_cmd.group == ssr_group_e'(g));
         assign rise = cond_reg[g] & ~prev_reg[g];
         assign fall = ~cond_reg[g] & prev_reg[g];
         // event read clears; clear status; preset
         assign evt_clear[g] = i_clear_status | i_preset |
                               (i_cmd.read & hit & (i_cmd.sel == SSR_REG_EVENT));

         // Condition sampled then delayed once for edge detection
         always_ff @(posedge i_clock) begin
            if (i_reset) begin
               cond_reg[g] <= 16'h0000;
               prev_reg[g] <= 16'h0000;
            end else begin
               cond_reg[g] <= live[g];
               prev_reg[g] <= cond_reg[g];
            end
         end

         // Sticky events; a new edge in a clearing cycle still lands
         always_ff @(posedge i_clock) begin
            if (i_reset) begin
               event_reg[g] <= 16'h0000;
            end else begin
               event_reg[g] <= ((evt_clear[g] ? 16'h0000 : event_reg[g])
                               | (rise & ptr_reg[g]) | (fall & ntr_reg[g]))
                               & grp_mask[g];
            end
         end

         // Enable register: kept by clear status, zeroed by preset
         always_ff @(posedge i_clock) begin
            if (i_reset) begin
               enab_reg[g] <= ENABLE_PRESET;
            end else if (i_preset) begin
               enab_reg[g] <= ENABLE_PRESET;
            end else if (i_cmd.write && hit && i_cmd.sel == SSR_REG_ENAB) begin
               enab_reg[g] <= i_cmd.wdata & grp_mask[g];
            end
         end

         // Filters are touched only by reset, preset and direct writes
         always_ff @(posedge i_clock) begin
            if (i_reset) begin
               ptr_reg[g] <= PTR_PRESET & grp_mask[g];
               ntr_reg[g] <= NTR_PRESET;
            end else if (i_preset) begin
               ptr_reg[g] <= PTR_PRESET & grp_mask[g];
               ntr_reg[g] <= NTR_PRESET;
            end else begin
               if (i_cmd.write && hit && i_cmd.sel == SSR_REG_PTR)
                  ptr_reg[g] <= i_cmd.wdata & grp_mask[g];
               if (i_cmd.write && hit && i_cmd.sel == SSR_REG_NTR)
                  ntr_reg[g] <= i_cmd.wdata & grp_mask[g];
            end
         end

         assign grp_sum[g] = |(event_reg[g] & enab_reg[g]);
      end
   endgenerate

   // ==========================================================
   // Query answers, one cycle after the strobe
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_rsp <= '0;
      end else begin
         o_rsp.valid <= i_cmd.read;
         case (i_cmd.sel)
            SSR_REG_EVENT: o_rsp.data <= event_reg[i_cmd.group];
            SSR_REG_COND:  o_rsp.data <= cond_reg[i_cmd.group];
            SSR_REG_ENAB:  o_rsp.data <= enab_reg[i_cmd.group];
            SSR_REG_NTR:   o_rsp.data <= ntr_reg[i_cmd.group];
            SSR_REG_PTR:   o_rsp.data <= ptr_reg[i_cmd.group];
            default:       o_rsp.data <= 16'h0000;
         endcase
      end
   end

   // ==========================================================
   // Status byte composition from present state
   always_comb begin
      sb_next = 8'h00;
      sb_next[SB_ERRQ_BIT] = i_errq_nonempty;
      sb_next[SB_QUES_BIT] = grp_sum[0];
      sb_next[SB_MAV_BIT]  = i_outbuf_nonempty;
      sb_next[SB_STDE_BIT] = i_std_event_any;
      sb_next[SB_OPER_BIT] = grp_sum[1];
      // master summary of the selected bits
      sb_next[SB_MSS_BIT]  = |(sb_next & sre_reg & ~(8'h01 << SB_MSS_BIT));
   end

   // Service request enable, bit 6 cannot select itself
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         sre_reg <= SRE_RESET;
      end else if (i_sre_write) begin
         sre_reg <= i_sre_wdata & ~(8'h01 << SB_MSS_BIT);
      end
   end

   // Registered status byte and service request pulse
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_status_byte <= 8'h00;
         sb_prev_reg   <= 8'h00;
         o_srq         <= 1'b0;
         o_sre         <= SRE_RESET;
      end else begin
         o_status_byte <= sb_next;
         sb_prev_reg   <= sb_next;
         o_sre         <= sre_reg;
         o_srq         <= |(sb_next & ~sb_prev_reg & sre_reg);
      end
   end

endmodule : ssr_status
`default_nettype wire

//--- verif/ssr_status_sva.sv
// Concurrent checks on the status summary block ports
`timescale 1ns/10ps
`default_nettype none
module ssr_status_sva (
   // Clock, reset and levels
   input wire logic             i_clock, i_reset, i_prot_off, i_fref_bad,
   input wire logic             i_usb_lost, i_running, i_errq_nonempty,
   input wire logic             i_outbuf_nonempty, i_std_event_any,
   // Commands
   input wire logic             i_clear_status, i_preset, i_sre_write,
   input wire logic [7:0]       i_sre_wdata,
   input wire ssr_pkg::ssr_cmd_s i_cmd,
   // Outputs watched
   input wire ssr_pkg::ssr_rsp_s o_rsp,
   input wire logic [7:0]       o_status_byte, o_sre,
   input wire logic             o_srq
);
   import ssr_pkg::*;
   // ==========================================
   // Status byte sources, one cycle of lag, reset edge excluded; unused bits 1:0 zero
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);
   a_mav_follow: assert property (!$past(i_reset) |-> o_status_byte[4] == $past(i_outbuf_nonempty))
      else $error("message bit does not follow buffer level");
   a_unused_zero: assert property (o_status_byte[1:0] == 2'h0)
      else $error("unused status bits not zero");
   a_errq_bit: assert property (!$past(i_reset) |-> o_status_byte[2] == $past(i_errq_nonempty))
      else $error("error queue bit wrong");
   a_std_bit: assert property (!$past(i_reset) |-> o_status_byte[5] == $past(i_std_event_any))
      else $error("standard event bit wrong");
   // ==========================================
   // Query answers and unused bits
   a_rsp_timing: assert property (!$past(i_reset) |-> o_rsp.valid == $past(i_cmd.read))
      else $error("answer valid not one cycle after query");
   a_ques_unused: assert property (i_cmd.read && i_cmd.group == SSR_GRP_QUES |=> (o_rsp.data & ~QUES_MASK) == 16'h0000)
      else $error("unassigned questionable bit read high");
   a_oper_unused: assert property (i_cmd.read && i_cmd.group == SSR_GRP_OPER |=> (o_rsp.data & ~OPER_MASK) == 16'h0000)
      else $error("unassigned operation bit read high");
   // ==========================================
   // Preset, service request mask and request cause
   a_preset_clear: assert property (i_preset |-> ##2 (o_status_byte[3] == 1'b0 && o_status_byte[7] == 1'b0))
      else $error("group summary survives preset");
   a_sre_mask: assert property (i_sre_write |=> ##1 o_sre == ($past(i_sre_wdata, 2) & 8'hbf))
      else $error("service mask not loaded");
   a_srq_cause: assert property (o_srq |-> (o_status_byte & o_sre) != 8'h00)
      else $error("service request without selected bit");
   c_srq: cover property (o_srq);
   c_ques: cover property (o_status_byte[3]);
   c_oper: cover property (o_status_byte[7]);
endmodule : ssr_status_sva
bind ssr_status ssr_status_sva ssr_status_sva_inst (.i_clock, .i_reset, .i_prot_off, .i_fref_bad,
   .i_usb_lost, .i_running, .i_errq_nonempty, .i_outbuf_nonempty, .i_std_event_any,
   .i_clear_status, .i_preset, .i_sre_write, .i_sre_wdata, .i_cmd, .o_rsp, .o_status_byte,
   .o_sre, .o_srq);
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking testbench for the status summary block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import ssr_pkg::*;
   // ==========================================
   // Stimulus: src is prot, fref, usb, run, errq, outbuf, std
   logic        i_clock = 1'b0;
   logic        i_reset = 1'b1;
   logic [6:0]  src = 7'h00;
   logic        clr = 1'b0;
   logic        pre = 1'b0;
   logic        srew = 1'b0;
   ssr_cmd_s    i_cmd = '0;
   ssr_rsp_s    o_rsp;
   logic [7:0]  sb, sre;
   logic        srq;
   logic [15:0] d;
   logic [15:0] rv;
   int          error_cnt = 0, checks_done = 0, cycles = 0, seed = 36;
   always #5 i_clock = ~i_clock;
   ssr_status ssr_status_inst (.i_clock, .i_reset, .i_prot_off(src[0]), .i_fref_bad(src[1]),
      .i_usb_lost(src[2]), .i_running(src[3]), .i_errq_nonempty(src[4]),
      .i_outbuf_nonempty(src[5]), .i_std_event_any(src[6]), .i_clear_status(clr),
      .i_preset(pre), .i_sre_write(srew), .i_sre_wdata(8'hff), .i_cmd, .o_rsp,
      .o_status_byte(sb), .o_sre(sre), .o_srq(srq));
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic w(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : w
   // One access; cleared afterwards so a following call starts a cycle later
   task automatic acc(input logic rd, input ssr_group_e g, input ssr_reg_e s,
                      input logic [15:0] v);
      i_cmd = '{rd, !rd, g, s, v};
      w(1);
      d = o_rsp.data;
      if (rd) chk({15'h0000, o_rsp.valid}, 16'h0001);
      i_cmd = '0;
      w(1);
   endtask : acc
   task automatic rc(input ssr_group_e g, input ssr_reg_e s, input logic [15:0] exp);
      acc(1'b1, g, s, 16'h0000);
      chk(d, exp);
   endtask : rc
   // Status byte from the three outside levels when no group summary is active
   function automatic logic [15:0] sb_exp(input logic [2:0] s);
      return {8'h00, 2'b00, s[2], s[1], 1'b0, s[0], 2'b00};
   endfunction : sb_exp
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   // Hang guard, well above the roughly 140 cycles the tests take
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   // ==========================================
   // Main sequence
   initial begin
      w(16);
      i_reset = 1'b0;
      rc(SSR_GRP_QUES, SSR_REG_PTR, QUES_MASK);
      rc(SSR_GRP_OPER, SSR_REG_PTR, OPER_MASK);
      rc(SSR_GRP_QUES, SSR_REG_NTR, 16'h0000);
      acc(1'b0, SSR_GRP_QUES, SSR_REG_EVENT, 16'hffff);
      rc(SSR_GRP_QUES, SSR_REG_EVENT, 16'h0000);
      repeat (6) begin
         rv = 16'($random(seed));
         acc(1'b0, SSR_GRP_QUES, SSR_REG_ENAB, rv);
         rc(SSR_GRP_QUES, SSR_REG_ENAB, rv & QUES_MASK);
         src[6:4] = 3'($random(seed));
         w(2);
         chk({8'h00, sb}, sb_exp(src[6:4]));
      end
      src[6:4] = 3'h0;
      $display("Test reset and summary levels done");
      acc(1'b0, SSR_GRP_QUES, SSR_REG_ENAB, 16'h00a1);
      srew = 1'b1;
      w(1);
      srew = 1'b0;
      w(1);
      chk({8'h00, sre}, 16'h00bf);
      src[1] = 1'b1;
      w(4);
      chk({8'h00, sb}, 16'h0048);
      rc(SSR_GRP_QUES, SSR_REG_COND, 16'h0020);
      rc(SSR_GRP_QUES, SSR_REG_EVENT, 16'h0020);
      rc(SSR_GRP_QUES, SSR_REG_EVENT, 16'h0000);
      chk({8'h00, sb}, 16'h0000);
      acc(1'b0, SSR_GRP_QUES, SSR_REG_PTR, 16'h0000);
      acc(1'b0, SSR_GRP_QUES, SSR_REG_NTR, 16'h00a1);
      src[1] = 1'b0;
      w(4);
      rc(SSR_GRP_QUES, SSR_REG_EVENT, 16'h0020);
      acc(1'b0, SSR_GRP_QUES, SSR_REG_NTR, 16'h0000);
      src[1] = 1'b1;
      w(4);
      rc(SSR_GRP_QUES, SSR_REG_EVENT, 16'h0000);
      acc(1'b0, SSR_GRP_QUES, SSR_REG_PTR, 16'h00a1);
      acc(1'b0, SSR_GRP_QUES, SSR_REG_NTR, 16'h00a1);
      src[0] = 1'b1;
      w(4);
      rc(SSR_GRP_QUES, SSR_REG_EVENT, 16'h0001);
      src[0] = 1'b0;
      w(4);
      rc(SSR_GRP_QUES, SSR_REG_EVENT, 16'h0001);
      $display("Test transition filters done");
      src[2] = 1'b1;
      w(4);
      chk({8'h00, sb}, 16'h0048);
      rc(SSR_GRP_QUES, SSR_REG_COND, 16'h00a0);
      clr = 1'b1;
      w(1);
      clr = 1'b0;
      w(2);
      chk({8'h00, sb}, 16'h0000);
      rc(SSR_GRP_QUES, SSR_REG_EVENT, 16'h0000);
      rc(SSR_GRP_QUES, SSR_REG_ENAB, 16'h00a1);
      rc(SSR_GRP_QUES, SSR_REG_NTR, 16'h00a1);
      $display("Test clear status done");
      acc(1'b0, SSR_GRP_OPER, SSR_REG_ENAB, 16'hffff);
      src[3] = 1'b1;
      w(3);
      chk({15'h0000, srq}, 16'h0001);
      w(1);
      chk({15'h0000, srq}, 16'h0000);
      chk({8'h00, sb}, 16'h00c0);
      rc(SSR_GRP_OPER, SSR_REG_COND, 16'h0100);
      $display("Test operation group done");
      pre = 1'b1;
      w(1);
      pre = 1'b0;
      w(2);
      chk({8'h00, sb}, 16'h0000);
      rc(SSR_GRP_OPER, SSR_REG_ENAB, ENABLE_PRESET);
      rc(SSR_GRP_QUES, SSR_REG_PTR, QUES_MASK);
      rc(SSR_GRP_QUES, SSR_REG_NTR, NTR_PRESET);
      $display("Test preset done");
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
